// >>> rtl/sar_adc_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef SAR_ADC_MAP_SVH
`define SAR_ADC_MAP_SVH
`define ADC_CONTROL_ONE_IDX 8'h0E
`define ADC_CONTROL_TWO_IDX 8'h0F
`define ADC_RESULT_LOW_STATUS_IDX 8'h20
`define ADC_RESULT_HIGH_IDX 8'h21
`define ADC_POWER_CTRL_IDX 8'h30
`define ADC_SAR_DATA_IDX 8'h31
`define ADC_CONTROL_ONE_RST 8'h10
`define ADC_CONTROL_TWO_RST 8'h10
`define START_BIT 7
`define MODE_HI 6
`define MODE_LO 5
`define AIN_DIS_BIT 4
`define CHAN_HI 3
`define CHAN_LO 0
`define LADDER_BIT 5
`define FIXED_ONE_BIT 4
`define TIME_HI 3
`define TIME_LO 1
`define END_FLAG_BIT 5
`define BUSY_FLAG_BIT 4
`define CYC_000 11'd39
`define CYC_010 11'd78
`define CYC_011 11'd156
`define CYC_100 11'd312
`define CYC_101 11'd624
`define CYC_110 11'd1248
`endif

// >>> rtl/sar_adc_pkg.sv
// Types shared by the converter sequencer
package sar_adc_pkg;
    typedef enum logic [1:0] {
        MODE_OFF = 2'h0,
        MODE_SOFT = 2'h1,
        MODE_RSVD = 2'h2,
        MODE_REPEAT = 2'h3
    } op_mode_type;
    typedef enum {
        ST_IDLE,
        ST_CONV
    } seq_state_type;
endpackage : sar_adc_pkg

// >>> rtl/result_store.sv
// Small register memory holding the last stored conversion result
`timescale 1ns/1ps
module result_store #(
    parameter int WIDTH = 10
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wr_i,
    input wire logic [WIDTH-1:0] wdata_i,
    output logic [WIDTH-1:0] rdata_o
);
    // Refused at elaboration, before any logic exists
    if (WIDTH < 1) begin : g_bad_width
        $error("WIDTH must be positive");
    end
    logic [WIDTH-1:0] mem_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mem_q <= '0;
        end else if (wr_i) begin
            mem_q <= wdata_i;
        end
    end
    assign rdata_o = mem_q;
endmodule : result_store

// >>> rtl/sar_adc_sequencer.sv
// Control, sequencing and status for the 10-bit SAR converter
`timescale 1ns/1ps
`include "sar_adc_map.svh"
// Function
// RULE_01 - Mode 00 off, 01 software start, 11 repeat, 10 reserved.
// RULE_02 - In software mode writing start converts the selected channel.
// RULE_03 - Start bit clears itself once conversion has begun.
// RULE_04 - Channel codes 0 to 7 pick inputs; 8 upward reserved.
// RULE_05 - Analog input control bit one disables the inputs.
// RULE_06 - Software changes channel only while busy reads zero.
// RULE_07 - Low-power entry resets both control registers and blocks writes.
// RULE_08 - Time code selects 39 to 1248 clock cycles; 001, 111 reserved.
// RULE_09 - Software avoids inhibited time codes at its clock rate.
// RULE_10 - Bit 5 selects ladder connected during conversion or always.
// RULE_11 - Software writes zero to bit 0 and one to bit 4.
// RULE_12 - Control two bits 6 and 7 read undefined.
// RULE_13 - Result bits 9..2 in high register, 1..0 in low bits 7..6.
// RULE_14 - Reading high result register clears the end flag.
// RULE_15 - Busy sets at start, clears at finish or low-power entry.
// RULE_16 - Low status register bits 3..0 read unstable data.
// RULE_17 - Completion stores result, sets end flag and raises interrupt.
// RULE_18 - Software does not restart while a conversion runs.
// RULE_19 - Repeat mode starts the next conversion after each completion.
// RULE_20 - Writing mode 00 aborts at once and discards the partial result.
// RULE_21 - Count selected cycles and make ten MSB-first bit decisions.
module sar_adc_sequencer #(
    parameter int RES_BITS = 10
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic comp_i,
    output logic [3:0] channel_select_o,
    output logic analog_in_disable_o,
    output logic ladder_on_o,
    output logic sample_o,
    output logic [RES_BITS-1:0] dac_code_o,
    output logic conv_done_irq_o
);
    // Bit layout of the result registers is fixed at ten bits
    if (RES_BITS != 10) begin : g_bad_res
        $error("RES_BITS must be 10");
    end
    // Register image
    logic [7:0] ctl1_q;
    // Bits 6 and 7 are not kept; they read as zero
    logic [5:0] ctl2_q;
    logic low_power_q;
    logic end_flag_q;
    logic busy_q;
    logic ack_q;
    logic [31:0] rdat_q;
    logic irq_q;
    logic [10:0] cyc_cnt_q;
    logic [10:0] conv_len_q;
    logic [3:0] bit_idx_q;
    logic [9:0] sar_q;
    logic [9:0] result;
    logic store;
    sar_adc_pkg::seq_state_type state_q;
    // Time code to cycle count
    function automatic logic [10:0] conv_cycles(input logic [2:0] code);
        unique case (code)
            3'h0: conv_cycles = `CYC_000;
            3'h2: conv_cycles = `CYC_010;
            3'h3: conv_cycles = `CYC_011;
            3'h4: conv_cycles = `CYC_100;
            3'h5: conv_cycles = `CYC_101;
            3'h6: conv_cycles = `CYC_110;
            default: conv_cycles = `CYC_000;
        endcase
    endfunction : conv_cycles
    function automatic logic sel_idx(input logic [7:0] adr,
            input logic [7:0] idx);
        sel_idx = (adr == {idx[5:0], 2'h0});
    endfunction : sel_idx
    // Bus decode
    logic bus_req;
    logic wr_lane0;
    logic wr_ctl1;
    logic wr_ctl2;
    logic rd_high;
    sar_adc_pkg::op_mode_type mode;
    logic start_req;
    logic abort;
    assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr_lane0 = bus_req && wb_we_i && wb_sel_i[0];
    assign wr_ctl1 = wr_lane0 && !low_power_q &&
        sel_idx(wb_adr_i, `ADC_CONTROL_ONE_IDX); // RULE_07
    assign wr_ctl2 = wr_lane0 && !low_power_q &&
        sel_idx(wb_adr_i, `ADC_CONTROL_TWO_IDX); // RULE_07
    assign rd_high = bus_req && !wb_we_i &&
        sel_idx(wb_adr_i, `ADC_RESULT_HIGH_IDX);
    assign mode = sar_adc_pkg::op_mode_type'(ctl1_q[`MODE_HI:`MODE_LO]);
    // Reserved mode 10 never starts
    assign start_req = ctl1_q[`START_BIT] &&
        (mode == sar_adc_pkg::MODE_SOFT ||
        mode == sar_adc_pkg::MODE_REPEAT); // RULE_01 RULE_02
    assign abort = low_power_q ||
        (mode == sar_adc_pkg::MODE_OFF); // RULE_20
    assign store = (state_q == sar_adc_pkg::ST_CONV) && !abort &&
        (cyc_cnt_q == conv_len_q - 11'd1);
    // Last decision folds into the stored value
    assign result = {sar_q[9:1], comp_i}; // RULE_21
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= bus_req;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            low_power_q <= 1'b0;
        end else if (wr_lane0 && sel_idx(wb_adr_i, `ADC_POWER_CTRL_IDX)) begin
            low_power_q <= wb_dat_i[0];
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i || low_power_q) begin
            ctl1_q <= `ADC_CONTROL_ONE_RST; // RULE_07
        end else begin
            if (wr_ctl1) begin
                ctl1_q <= wb_dat_i[7:0];
            end
            if (state_q == sar_adc_pkg::ST_IDLE && start_req) begin
                ctl1_q[`START_BIT] <= 1'b0; // RULE_03
            end
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i || low_power_q) begin
            ctl2_q <= 6'(`ADC_CONTROL_TWO_RST); // RULE_07
        end else if (wr_ctl2) begin
            ctl2_q <= wb_dat_i[5:0];
        end
    end
    // Sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i || abort) begin
            state_q <= sar_adc_pkg::ST_IDLE; // RULE_20
            cyc_cnt_q <= 11'd0;
            bit_idx_q <= 4'd9;
            sar_q <= 10'h200;
            conv_len_q <= `CYC_000;
        end else begin
            unique case (state_q)
                sar_adc_pkg::ST_IDLE: begin
                    if (start_req) begin
                        state_q <= sar_adc_pkg::ST_CONV;
                        cyc_cnt_q <= 11'd0;
                        bit_idx_q <= 4'd9;
                        sar_q <= 10'h200;
                        conv_len_q <= conv_cycles(
                            ctl2_q[`TIME_HI:`TIME_LO]); // RULE_08
                    end
                end
                sar_adc_pkg::ST_CONV: begin
                    cyc_cnt_q <= cyc_cnt_q + 11'd1; // RULE_21
                    // One decision every len/10 cycles, last at the end
                    if (store) begin
                        cyc_cnt_q <= 11'd0;
                        sar_q <= 10'h200;
                        bit_idx_q <= 4'd9;
                        if (mode != sar_adc_pkg::MODE_REPEAT) begin
                            state_q <= sar_adc_pkg::ST_IDLE;
                        end // RULE_19
                    end else if (bit_idx_q != 4'd0 &&
                        cyc_cnt_q == (conv_len_q / 11'd10) *
                        (11'd10 - {7'd0, bit_idx_q}) - 11'd1) begin
                        sar_q[bit_idx_q] <= comp_i; // RULE_21
                        sar_q[bit_idx_q - 4'd1] <= 1'b1;
                        bit_idx_q <= bit_idx_q - 4'd1;
                    end
                end
            endcase
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i || low_power_q) begin
            busy_q <= 1'b0; // RULE_15
        end else if (state_q == sar_adc_pkg::ST_IDLE && start_req) begin
            busy_q <= 1'b1; // RULE_15
        end else if (abort ||
            (store && mode != sar_adc_pkg::MODE_REPEAT)) begin
            busy_q <= 1'b0; // RULE_15
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i || low_power_q) begin
            end_flag_q <= 1'b0;
        end else if (store) begin
            end_flag_q <= 1'b1; // RULE_17
        end else if (rd_high) begin
            end_flag_q <= 1'b0; // RULE_14
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= store; // RULE_17
        end
    end
    logic [9:0] res_q;
    logic res_clr;
    assign res_clr = rst_i || low_power_q;
    result_store #(
        .WIDTH(10)
    ) u_result (
        .clk_i(clk_i),
        .rst_i(res_clr),
        .wr_i(store), // RULE_17
        .wdata_i(result),
        .rdata_o(res_q)
    );
    // Read mux
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_q <= 32'h0;
        end else if (bus_req && !wb_we_i) begin
            rdat_q <= 32'h0;
            if (sel_idx(wb_adr_i, `ADC_CONTROL_ONE_IDX)) begin
                rdat_q[7:0] <= ctl1_q;
            end else if (sel_idx(wb_adr_i, `ADC_CONTROL_TWO_IDX)) begin
                // Upper two bits undefined; drive zero
                rdat_q[7:0] <= {2'h0, ctl2_q}; // RULE_12
            end else if (sel_idx(wb_adr_i, `ADC_RESULT_HIGH_IDX)) begin
                rdat_q[7:0] <= res_q[9:2]; // RULE_13
            end else if (sel_idx(wb_adr_i,
                `ADC_RESULT_LOW_STATUS_IDX)) begin
                // Unstable low nibble shows the live SAR bits
                rdat_q[7:0] <= {res_q[1:0], end_flag_q, busy_q,
                    sar_q[3:0]}; // RULE_13 RULE_16
            end else if (sel_idx(wb_adr_i, `ADC_POWER_CTRL_IDX)) begin
                rdat_q[0] <= low_power_q;
            end else if (sel_idx(wb_adr_i, `ADC_SAR_DATA_IDX)) begin
                rdat_q[9:0] <= sar_q;
            end
        end
    end
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign conv_done_irq_o = irq_q;
    assign channel_select_o = ctl1_q[`CHAN_HI:`CHAN_LO]; // RULE_04
    assign analog_in_disable_o = ctl1_q[`AIN_DIS_BIT]; // RULE_05
    assign ladder_on_o = !low_power_q && (ctl2_q[`LADDER_BIT] ||
        state_q == sar_adc_pkg::ST_CONV); // RULE_10
    assign sample_o = (state_q == sar_adc_pkg::ST_CONV) && bit_idx_q == 4'd9;
    assign dac_code_o = sar_q;
endmodule : sar_adc_sequencer

// >>> dv/sar_adc_props.sv
// Port-level checks for the converter sequencer
`timescale 1ns/1ps
module sar_adc_props #(
    parameter int RES_BITS = 10
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [3:0] channel_select_o,
    input wire logic analog_in_disable_o,
    input wire logic ladder_on_o,
    input wire logic sample_o,
    input wire logic [RES_BITS-1:0] dac_code_o,
    input wire logic conv_done_irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic lp_q;
    logic [11:0] len_q;
    logic take, wr1;
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr1 = take && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h38;
    // Low-power state mirrored from bus writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lp_q <= 1'b0;
        end else if (take && wb_we_i && wb_sel_i[0] &&
            wb_adr_i == 8'hC0) begin
            lp_q <= wb_dat_i[0];
        end
    end
    // Saturating count from the first trial bit
    always_ff @(posedge clk_i) begin
        if (rst_i || $rose(sample_o)) begin
            len_q <= 12'h000;
        end else if (len_q != 12'hFFF) begin
            len_q <= len_q + 12'h001;
        end
    end
    property p_ack; take |=> wb_ack_o; endproperty
    property p_ack_drop; wb_ack_o |=> !wb_ack_o; endproperty
    property p_unmap;
        take && !wb_we_i && !(wb_adr_i inside {8'h38, 8'h3C, 8'h80,
            8'h84, 8'hC0, 8'hC4}) |=> wb_dat_o == 32'h0;
    endproperty
    property p_ctl;
        wr1 && !lp_q |=> channel_select_o == $past(wb_dat_i[3:0])
            && analog_in_disable_o == $past(wb_dat_i[4]);
    endproperty
    property p_lp;
        lp_q |=> !ladder_on_o && channel_select_o == 4'h0
            && analog_in_disable_o;
    endproperty
    property p_irq; conv_done_irq_o |=> !conv_done_irq_o; endproperty
    // Count runs from the first trial, so it shows length minus one
    property p_len;
        conv_done_irq_o |-> len_q >= 12'd38 && len_q <= 12'd1247;
    endproperty
    property p_msb;
        $rose(sample_o) |-> dac_code_o == {1'b1, {(RES_BITS-1){1'b0}}};
    endproperty
    property p_abort;
        wr1 && wb_dat_i[6:5] == 2'b00 |-> ##3 !conv_done_irq_o [*8];
    endproperty
    a_ack: assert property (p_ack) else $error("ack missing");
    a_ack_drop: assert property (p_ack_drop) else $error("ack held");
    a_unmap: assert property (p_unmap) else $error("unmapped data");
    a_ctl: assert property (p_ctl) else $error("ctl pins");
    a_lp: assert property (p_lp) else $error("low power");
    a_irq: assert property (p_irq) else $error("irq width");
    a_len: assert property (p_len) else $error("conv short");
    a_msb: assert property (p_msb) else $error("first trial");
    a_abort: assert property (p_abort) else $error("irq after off");
    c_irq: cover property (conv_done_irq_o);
    c_abort: cover property (wr1 && wb_dat_i[6:5] == 2'b00);
    c_lp: cover property ($rose(lp_q));
endmodule : sar_adc_props
bind sar_adc_sequencer sar_adc_props #(.RES_BITS(RES_BITS)) props_u (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .channel_select_o(channel_select_o),
    .analog_in_disable_o(analog_in_disable_o),
    .ladder_on_o(ladder_on_o),
    .sample_o(sample_o),
    .dac_code_o(dac_code_o),
    .conv_done_irq_o(conv_done_irq_o)
);

// >>> dv/sar_adc_sequencer_tb_top.sv
// Register-level bench for the converter sequencer
`timescale 1ns/1ps
module sar_adc_sequencer_tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, we = 1'b0, comp = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, dout, rdat;
    logic ack, irq, ain, lad, smp;
    logic [3:0] chan;
    logic [9:0] dac;
    logic [2:0] tc;
    int err_total = 0;
    int checks_done = 0;
    int n, cy;
    always #4 clk_i = ~clk_i;
    sar_adc_sequencer dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
        .wb_dat_i(wdat), .wb_dat_o(dout), .wb_ack_o(ack), .comp_i(comp),
        .channel_select_o(chan), .analog_in_disable_o(ain),
        .ladder_on_o(lad), .sample_o(smp), .dac_code_o(dac),
        .conv_done_irq_o(irq));
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude
    task automatic chk(input string nm, input logic [31:0] e, g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    // Classic cycle; only the watchdog ends a wait for ack
    task automatic acc(input logic w, input logic [7:0] a, d);
        @(posedge clk_i);
        chk("ack_idle", 32'h0, {31'h0, ack});
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        do @(posedge clk_i); while (ack !== 1'b1);
        rdat = dout;
        cyc <= 1'b0;
        we <= 1'b0;
    endtask : acc
    task automatic rd(input logic [7:0] a, e, m);
        acc(1'b0, a, 8'h00);
        chk($sformatf("reg %h", a), {24'h0, e}, rdat & {24'h0, m});
    endtask : rd
    task automatic wait_irq(output int k);
        k = 0;
        while (irq !== 1'b1 && k < 2000) begin
            @(posedge clk_i);
            k++;
        end
    endtask : wait_irq
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(8'h38, 8'h10, 8'hFF);
        rd(8'h3C, 8'h10, 8'hFF);
        rd(8'h84, 8'h00, 8'hFF);
        rd(8'h80, 8'h00, 8'hF0);
        rd(8'h10, 8'h00, 8'hFF);
        $display("done: reset");
        for (int i = 0; i < 6; i++) begin
            tc = (i == 0) ? 3'h0 : 3'(i + 1);
            cy = 39 << i;
            comp <= i[0];
            acc(1'b1, 8'h3C, 8'h10 | {4'h0, tc, 1'b0});
            acc(1'b1, 8'h38, 8'hA0 | 8'(i));
            wait_irq(n);
            chk("len", 32'h1, 32'(n >= cy - 1 && n <= cy + 4));
            chk("chan", 32'(i), {28'h0, chan});
            chk("ain", 32'h0, {31'h0, ain});
            chk("ladder", 32'h0, {31'h0, lad});
            rd(8'h38, 8'h20 | 8'(i), 8'hFF);
            rd(8'h80, {i[0], i[0], 6'h20}, 8'hF0);
            rd(8'h84, {8{i[0]}}, 8'hFF);
            rd(8'h80, {i[0], i[0], 6'h00}, 8'hF0);
        end
        $display("done: single");
        acc(1'b1, 8'h3C, 8'h10);
        acc(1'b1, 8'h38, 8'hE3);
        wait_irq(n);
        @(posedge clk_i);
        wait_irq(n);
        chk("repeat", 32'h1, 32'(n >= 37 && n <= 44));
        rd(8'h84, 8'hFF, 8'hFF);
        comp <= 1'b0;
        repeat (10) @(posedge clk_i);
        acc(1'b1, 8'h38, 8'h03);
        wait_irq(n);
        chk("abort", 32'd2000, 32'(n));
        rd(8'h80, 8'hC0, 8'hF0);
        rd(8'h84, 8'hFF, 8'hFF);
        $display("done: repeat");
        acc(1'b1, 8'h3C, 8'h30);
        acc(1'b1, 8'h38, 8'hB5);
        repeat (2) @(posedge clk_i);
        chk("ladder_on", 32'h1, {31'h0, lad});
        chk("ain_off", 32'h1, {31'h0, ain});
        acc(1'b1, 8'hC0, 8'h01);
        rd(8'h80, 8'h00, 8'hF0);
        acc(1'b1, 8'h38, 8'h25);
        rd(8'h38, 8'h10, 8'hFF);
        rd(8'h3C, 8'h10, 8'hFF);
        chk("lp_ladder", 32'h0, {31'h0, lad});
        acc(1'b1, 8'hC0, 8'h00);
        acc(1'b1, 8'h38, 8'h25);
        rd(8'h38, 8'h25, 8'hFF);
        $display("done: low power");
        // Reserved mode with start set must not convert
        acc(1'b1, 8'h38, 8'hC5);
        rd(8'h80, 8'h00, 8'h30);
        rd(8'h38, 8'hC5, 8'hFF);
        $display("done: reserved mode");
        conclude;
    end
    // Whole run is near 4700 cycles
    initial begin
        #300000;
        err_total++;
        conclude;
    end
endmodule : sar_adc_sequencer_tb_top
